// *** hdl/sfs_pkg.sv ***
// Purpose: constants and carriers of the safety fault supervisor
// Assumes: 20 MHz core clock, Avalon-MM register access
// Notes  : comparator and fault inputs are asynchronous pins
package sfs_pkg;
   localparam int CLK_MHZ     = 20;
   localparam int DB_BASE_NS  = 1000;
   localparam int DB_BASE_CYC = (DB_BASE_NS * CLK_MHZ + 999) / 1000;
   localparam int KA_BASE_US  = 1000;
   localparam int KA_BASE_CYC = KA_BASE_US * CLK_MHZ;
   localparam int FT_BASE_US  = 500;
   localparam int FT_BASE_CYC = FT_BASE_US * CLK_MHZ;
   localparam int NCH         = 4;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DB   = 8'h04;
   localparam logic [7:0] OFS_STS  = 8'h08;
   localparam logic [7:0] OFS_KA   = 8'h0c;
   localparam logic [7:0] OFS_ST   = 8'h10;
   localparam logic [7:0] OFS_OTP  = 8'h14;
   localparam int CTRL_UNLOCK = 31;
   localparam int STS_UV  = 0;
   localparam int STS_OV  = 4;
   localparam int STS_BIST = 8;
   localparam int STS_LINK = 9;
   localparam int STS_TMO  = 10;
   localparam int STS_W    = 11;
   localparam logic [1:0] ILIM_TRIP = 2'h2;
   typedef struct packed {
      logic       byp_ovr;
      logic       byp_uvf;
      logic [1:0] ka_sel;
      logic [1:0] ft_sel;
      logic       auto_rearm;
      logic       selftest_retry_enable;
      logic       rst_en;
      logic       off_en;
   } sfs_cfg_s;
   typedef struct packed {
      logic [2:0] ov_fall;
      logic [2:0] ov_rise;
      logic [2:0] uv_rise;
      logic [2:0] uv_fall;
   } sfs_db_s;
   localparam sfs_cfg_s CFG_RST = 10'h003;
   localparam sfs_db_s  DB_RST  = 12'h000;
   typedef enum logic [2:0] {
      ST_INIT   = 3'b000,
      ST_BIST   = 3'b001,
      ST_ACTIVE = 3'b010,
      ST_FLAG   = 3'b011,
      ST_RESET  = 3'b100,
      ST_LOCK   = 3'b101,
      ST_ERRPD  = 3'b110,
      ST_FLTPD  = 3'b111
   } sfs_state_e;
endpackage

// *** hdl/sfs_top.sv ***
// Purpose: safety fault supervisor with Avalon-MM registers
// Assumes: i_core_clk 20 MHz, synchronous active-high i_sys_rst
// Notes  : one cycle of waitrequest on every access
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/100ps
module sfs_top #(
   parameter int KA_BASE = sfs_pkg::KA_BASE_CYC,
   parameter int FT_BASE = sfs_pkg::FT_BASE_CYC
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_sys_rst,
   input  wire logic [7:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   input  wire logic [3:0]  i_uv_cmp,
   input  wire logic [3:0]  i_ov_cmp,
   input  wire logic [3:0]  i_ilim_pos,
   input  wire logic [3:0]  i_ilim_neg,
   input  wire logic [3:0]  i_sw_short,
   input  wire logic        i_core_ref_short,
   input  wire logic        i_clk_fault,
   input  wire logic        i_bist_done,
   input  wire logic        i_bist_pass,
   input  wire logic        i_otp_vld,
   input  wire logic [31:0] i_otp_word,
   output logic             o_bist_start,
   output logic [25:0]      o_otp_payload,
   output logic             o_rails_off,
   output logic             o_rst_n,
   output logic             o_int_n
);
   import sfs_pkg::*;

   if (KA_BASE < 1 || KA_BASE > 1048576 || FT_BASE < 1 || FT_BASE > 1048576)
   begin : g_chk
      $error("timer base out of range");
   end

   function automatic logic [11:0] db_lim(input logic [2:0] code);
      db_lim = 12'(DB_BASE_CYC << code);
   endfunction

   function automatic logic [34:0] ecc_fix(input logic [31:0] w);
      logic [4:0]  syn;
      logic        par;
      logic [31:0] c;
      logic [25:0] d;
      int          k;
      syn = 5'h00;
      par = ^w;
      k = 0;
      d = 26'h0;
      for (int i = 1; i < 32; i++)
      begin
         if (w[i]) syn = syn ^ 5'(i);
      end
      c = w;
      if (par) c[syn] = ~c[syn];
      for (int i = 3; i < 32; i++)
      begin
         if ((i & (i - 1)) != 0)
         begin
            d[k] = c[i];
            k = k + 1;
         end
      end
      ecc_fix = {7'h00, par, !par && syn != 5'h00, d};
   endfunction

   // two stages before any logic reads a comparator or fault pin
   logic [21:0] s1_q;
   logic [21:0] s2_q;
   logic [7:0]  s3_q;
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         s1_q <= 22'h0;
         s2_q <= 22'h0;
         s3_q <= 8'h0;
      end
      else
      begin
         s1_q <= {i_uv_cmp, i_ov_cmp, i_ilim_pos, i_ilim_neg, i_sw_short,
                  i_core_ref_short, i_clk_fault};
         s2_q <= s1_q;
         s3_q <= s2_q[13:6];
      end
   end
   wire [3:0] uv_s = s2_q[21:18];
   wire [3:0] ov_s = s2_q[17:14];
   wire [3:0] ilp_e = s2_q[13:10] & ~s3_q[7:4];
   wire [3:0] iln_e = s2_q[9:6] & ~s3_q[3:0];
   wire       sw_any = |s2_q[5:2];
   wire       vc_s = s2_q[1];
   wire       cf_s = s2_q[0];

   sfs_cfg_s    cfg_q;
   sfs_db_s     db_q;
   logic        par_q;
   logic        ack_q;
   logic [STS_W-1:0] sts_q;
   sfs_state_e  st_q;
   sfs_state_e  st_d;
   logic        hard_q;
   logic        retried_q;
   logic        unlock_q;
   logic        ka_wr;
   logic        bist_fail;

   wire acc = i_avs_read || i_avs_write;
   wire wr = i_avs_write && ack_q;
   assign o_avs_waitrequest = acc && !ack_q;
   assign ka_wr = wr && i_avs_address == OFS_KA;

   wire integ_bad = par_q != ^{cfg_q, db_q};
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         ack_q <= 1'b0;
         cfg_q <= CFG_RST;
         db_q <= DB_RST;
         par_q <= ^{CFG_RST, DB_RST};
         unlock_q <= 1'b0;
      end
      else
      begin
         ack_q <= acc && !ack_q;
         unlock_q <= wr && i_avs_address == OFS_CTRL && i_avs_writedata[CTRL_UNLOCK];
         if (wr && i_avs_address == OFS_CTRL)
         begin
            cfg_q <= i_avs_writedata[9:0];
            par_q <= ^{i_avs_writedata[9:0], db_q};
         end
         if (wr && i_avs_address == OFS_DB)
         begin
            db_q <= i_avs_writedata[11:0];
            par_q <= ^{cfg_q, i_avs_writedata[11:0]};
         end
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
         o_avs_readdata <= 32'h0;
      else if (i_avs_read && !ack_q)
      begin
         case (i_avs_address)
            OFS_CTRL: o_avs_readdata <= {22'h0, cfg_q};
            OFS_DB:   o_avs_readdata <= {20'h0, db_q};
            OFS_STS:  o_avs_readdata <= {21'h0, sts_q};
            OFS_ST:   o_avs_readdata <= {26'h0, o_rails_off, hard_q, 1'b0, st_q};
            OFS_OTP:  o_avs_readdata <= {6'h0, o_otp_payload};
            default:  o_avs_readdata <= 32'h0;
         endcase
      end
   end

   logic [3:0]  uv_f_q;
   logic [3:0]  ov_f_q;
   logic [11:0] uv_c_q [NCH];
   logic [11:0] ov_c_q [NCH];
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         uv_f_q <= 4'h0;
         ov_f_q <= 4'h0;
         for (int c = 0; c < NCH; c++)
         begin
            uv_c_q[c] <= 12'h0;
            ov_c_q[c] <= 12'h0;
         end
      end
      else
      begin
         for (int c = 0; c < NCH; c++)
         begin
            uv_c_q[c] <= 12'h0;
            ov_c_q[c] <= 12'h0;
            if (uv_s[c] == uv_f_q[c])
               uv_f_q[c] <= uv_f_q[c];
            else if (uv_s[c] && cfg_q.byp_uvf)
               uv_f_q[c] <= 1'b1;
            else if (uv_c_q[c] == db_lim(uv_s[c] ? db_q.uv_fall : db_q.uv_rise) - 12'h1)
               uv_f_q[c] <= uv_s[c];
            else
               uv_c_q[c] <= uv_c_q[c] + 12'h1;
            if (ov_s[c] == ov_f_q[c])
               ov_f_q[c] <= ov_f_q[c];
            else if (ov_s[c] && cfg_q.byp_ovr)
               ov_f_q[c] <= 1'b1;
            else if (ov_c_q[c] == db_lim(ov_s[c] ? db_q.ov_rise : db_q.ov_fall) - 12'h1)
               ov_f_q[c] <= ov_s[c];
            else
               ov_c_q[c] <= ov_c_q[c] + 12'h1;
         end
      end
   end
   a_uv_debounce_time: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      $rose(uv_f_q[0]) && !$past(cfg_q.byp_uvf)
      |-> $past(uv_c_q[0]) == db_lim($past(db_q.uv_fall)) - 12'h1)
      else $error("uv filter released early");

   logic [1:0] ilp_q [NCH];
   logic [1:0] iln_q [NCH];
   logic       trip;
   always_comb
   begin
      trip = 1'b0;
      for (int c = 0; c < NCH; c++)
         trip = trip || ilp_q[c] == ILIM_TRIP || iln_q[c] == ILIM_TRIP;
   end
   always_ff @(posedge i_core_clk)
   begin
      for (int c = 0; c < NCH; c++)
      begin
         if (i_sys_rst || !uv_f_q[c])
            ilp_q[c] <= 2'h0;
         else if (ilp_e[c] && ilp_q[c] != ILIM_TRIP)
            ilp_q[c] <= ilp_q[c] + 2'h1;
         if (i_sys_rst || !ov_f_q[c])
            iln_q[c] <= 2'h0;
         else if (iln_e[c] && iln_q[c] != ILIM_TRIP)
            iln_q[c] <= iln_q[c] + 2'h1;
      end
   end
   a_ilim_errpd: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      trip && !hard_q && !cf_s |=> st_q == ST_ERRPD)
      else $error("current-limit count did not power down");

   logic [23:0] ka_q;
   logic [23:0] ft_q;
   wire run = st_q == ST_ACTIVE || st_q == ST_FLAG;
   wire ka_trip = run && ka_q == 24'(KA_BASE << cfg_q.ka_sel) - 24'h1;
   wire ft_trip = st_q == ST_FLAG && ft_q == 24'(FT_BASE << cfg_q.ft_sel) - 24'h1;
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst || !run || ka_wr || ka_trip)
         ka_q <= 24'h0;
      else
         ka_q <= ka_q + 24'h1;
      if (i_sys_rst || st_q != ST_FLAG || ft_trip)
         ft_q <= 24'h0;
      else
         ft_q <= ft_q + 24'h1;
   end

   logic [34:0] ecc;
   assign ecc = ecc_fix(i_otp_word);
   wire ecc_dbl = i_otp_vld && ecc[26];
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
         o_otp_payload <= 26'h0;
      else if (i_otp_vld)
         o_otp_payload <= ecc[25:0];
   end

   // sticky flags: hardware set wins over write-one-clear
   assign bist_fail = st_q == ST_BIST && i_bist_done && !i_bist_pass;
   wire [STS_W-1:0] set = {ft_trip, ka_trip,
                           bist_fail || (i_otp_vld && (ecc[27] || ecc[26])),
                           ov_f_q, uv_f_q};
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
         sts_q <= '0;
      else if (wr && i_avs_address == OFS_STS)
         sts_q <= (sts_q & ~i_avs_writedata[STS_W-1:0]) | set;
      else
         sts_q <= sts_q | set;
   end
   a_link_loss: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      ka_trip |=> sts_q[STS_LINK] ##1 !o_int_n)
      else $error("keep-alive loss not flagged");
   a_ecc_flag: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      i_otp_vld && (ecc[27] || ecc[26]) |=> sts_q[STS_BIST])
      else $error("bank error not flagged");

   wire viol = |{uv_f_q, ov_f_q};
   wire rail_on = run && !(cfg_q.off_en && viol);
   wire clk_bad = cf_s && rail_on;
   always_comb
   begin
      st_d = st_q;
      if (hard_q || clk_bad)
         st_d = ST_LOCK;
      else if (sw_any || trip || st_q == ST_ERRPD)
         st_d = ST_ERRPD;
      else if (vc_s)
         st_d = ST_RESET;
      else if (ecc_dbl || integ_bad)
         st_d = ST_LOCK;
      else
      begin
         case (st_q)
            ST_INIT:   st_d = ST_BIST;
            ST_BIST:
            begin
               if (i_bist_done && i_bist_pass)
                  st_d = ST_ACTIVE;
               else if (bist_fail)
                  st_d = cfg_q.selftest_retry_enable && !retried_q ? ST_INIT : ST_LOCK;
            end
            ST_ACTIVE: st_d = |sts_q || ka_trip ? ST_FLAG : ST_ACTIVE;
            ST_FLAG:
            begin
               if (ft_trip)
                  st_d = ST_FLTPD;
               else if (sts_q == '0)
                  st_d = ST_ACTIVE;
            end
            ST_RESET:  st_d = ST_INIT;
            ST_LOCK:   st_d = unlock_q && !sts_q[STS_BIST] ? ST_INIT : ST_LOCK;
            ST_FLTPD:  st_d = cfg_q.auto_rearm ? ST_INIT : ST_LOCK;
            default:   st_d = ST_INIT;
         endcase
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         st_q <= ST_INIT;
         hard_q <= 1'b0;
         retried_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         if (clk_bad)
            hard_q <= 1'b1;
         if (bist_fail)
            retried_q <= 1'b1;
         else if (st_q == ST_BIST && i_bist_done)
            retried_q <= 1'b0;
      end
   end
   assign o_bist_start = st_q == ST_INIT;

   // registered so the pins never glitch on a state change
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         o_rails_off <= 1'b1;
         o_rst_n <= 1'b0;
         o_int_n <= 1'b1;
      end
      else
      begin
         o_rails_off <= !rail_on;
         o_rst_n <= run && !(cfg_q.rst_en && viol);
         o_int_n <= ~|sts_q;
      end
   end

   a_ref_short: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      st_q == ST_RESET && !vc_s && !hard_q && !sw_any && !trip && !ecc_dbl
      && !integ_bad |=> st_q == ST_INIT)
      else $error("reset state not left after short cleared");
   a_clk_lock: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      clk_bad |=> st_q == ST_LOCK ##1 st_q == ST_LOCK)
      else $error("clock fault did not lock");
   a_lock_off: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      st_q == ST_LOCK ##1 st_q == ST_LOCK |-> o_rails_off && !o_rst_n)
      else $error("rails on during lock");
   a_bist_retry: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      bist_fail && retried_q && st_d != ST_ERRPD && st_d != ST_RESET
      |=> st_q == ST_LOCK)
      else $error("second self-test failure not locked");
   a_sw_short: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      sw_any && !hard_q && !clk_bad |=> st_q == ST_ERRPD ##1 o_rails_off)
      else $error("switching short did not power down");
   a_fault_tmo: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      ft_trip && st_d == ST_FLTPD |=> st_q == ST_FLTPD && sts_q[STS_TMO])
      else $error("fault timeout not taken");
   a_viol_int: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      $rose(uv_f_q[0]) |-> ##2 !o_int_n)
      else $error("violation did not pull interrupt");
endmodule

// *** verification/sfs_host.sv ***
// Purpose: host model on the supervisor register bus
// Assumes: Avalon-MM slave answering through waitrequest
// Notes  : released address and data lines show the inverse of the last value
`timescale 1ns/100ps
module sfs_host (
   input  wire logic        i_core_clk,
   input  wire logic [31:0] i_avs_readdata,
   input  wire logic        i_avs_waitrequest,
   output logic [7:0]       o_avs_address,
   output logic             o_avs_read,
   output logic             o_avs_write,
   output logic [31:0]      o_avs_writedata,
   output int               o_lapses
);
   initial
   begin
      o_avs_address   = 8'h00;
      o_avs_read      = 1'b0;
      o_avs_write     = 1'b0;
      o_avs_writedata = 32'h0;
      o_lapses        = 0;
   end
   // held until waitrequest is seen low or 50 cycles pass; a timeout counts a lapse
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      int n;
      n = 0;
      @(posedge i_core_clk);
      o_avs_address   <= a;
      o_avs_writedata <= d;
      o_avs_read      <= ~w;
      o_avs_write     <= w;
      do
      begin
         @(posedge i_core_clk);
         n++;
      end
      while (i_avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50)
         o_lapses++;
      r = i_avs_readdata;
      o_avs_read      <= 1'b0;
      o_avs_write     <= 1'b0;
      o_avs_address   <= ~a;
      o_avs_writedata <= ~d;
   endtask
   task automatic kick();
      logic [31:0] r;
      xfer(1'b1, sfs_pkg::OFS_KA, 32'h1, r);
   endtask
endmodule

// *** verification/tb.sv ***
// Purpose: self-checking bench of the safety fault supervisor
// Assumes: short keep-alive and timeout bases, fresh boot per test
// Notes  : fault pins move on clock edges only
`timescale 1ns/100ps
module tb;
   import sfs_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  adr;
   logic        rde, wre, wq, bst, roff, rstn, intn;
   logic [31:0] wd, rdd, q;
   logic [3:0]  uv = '0, ov = '0, ilp = '0, iln = '0, sws = '0;
   logic        crs = 1'b0, ckf = 1'b0, bdn = 1'b0, bps = 1'b0, otv = 1'b0;
   logic [31:0] otw = '0;
   logic [25:0] pay;
   int          fail_count = 0, comparisons = 0, lapses;

   always #25 clk = ~clk;

   sfs_top #(.KA_BASE(20), .FT_BASE(10)) sfs_top_inst (
      .i_core_clk(clk), .i_sys_rst(rst), .i_avs_address(adr), .i_avs_read(rde),
      .i_avs_write(wre), .i_avs_writedata(wd), .o_avs_readdata(rdd),
      .o_avs_waitrequest(wq), .i_uv_cmp(uv), .i_ov_cmp(ov), .i_ilim_pos(ilp),
      .i_ilim_neg(iln), .i_sw_short(sws), .i_core_ref_short(crs), .i_clk_fault(ckf),
      .i_bist_done(bdn), .i_bist_pass(bps), .i_otp_vld(otv), .i_otp_word(otw),
      .o_bist_start(bst), .o_otp_payload(pay), .o_rails_off(roff), .o_rst_n(rstn),
      .o_int_n(intn));
   sfs_host sfs_host_inst (
      .i_core_clk(clk), .i_avs_readdata(rdd), .i_avs_waitrequest(wq),
      .o_avs_address(adr), .o_avs_read(rde), .o_avs_write(wre),
      .o_avs_writedata(wd), .o_lapses(lapses));

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      sfs_host_inst.xfer(1'b0, a, 32'h0, d);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] d;
      sfs_host_inst.xfer(1'b1, a, v, d);
   endtask
   // read a register and compare the masked value
   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      rd(a, q);
      chk($sformatf("reg %h", a), q & m, e);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic do_reset();
      rst <= 1'b1;
      {uv, ov, ilp, iln, sws} <= '0;
      {crs, ckf, bdn, bps, otv} <= '0;
      cyc(16);
      rst <= 1'b0;
   endtask
   // poll for the self-test state under a bound, then answer it
   task automatic bist(input logic pass);
      int n;
      n = 0;
      q = '0;
      while (q[2:0] !== 3'h1 && n < 20)
      begin
         rd(OFS_ST, q);
         n++;
      end
      chk("selftest entry", 32'(n < 20), 32'h1);
      if (n >= 20)
         close_out();
      bps <= pass;
      bdn <= 1'b1;
      @(posedge clk);
      bdn <= 1'b0;
      cyc(2);
   endtask
   task automatic boot(input logic [31:0] c);
      do_reset();
      bist(1'b1);
      wr(OFS_CTRL, c);
      sfs_host_inst.kick();
   endtask
   task automatic otp(input logic [31:0] w);
      otw <= w;
      otv <= 1'b1;
      @(posedge clk);
      otv <= 1'b0;
      cyc(3);
   endtask

   task automatic t_reset();
      do_reset();
      chk("rails_off", 32'(roff), 32'h1);
      chk("bist_start", 32'(bst), 32'h1);
      chk("int_n", 32'(intn), 32'h1);
      rc(OFS_CTRL, '1, 32'(CFG_RST));
      rc(OFS_DB, '1, 32'(DB_RST));
      wr(OFS_ST, 32'h2);
      rc(OFS_ST, 32'h7, 32'(ST_BIST));
      rc(8'h20, '1, 32'h0);
      bist(1'b1);
      rc(OFS_ST, 32'h7, 32'(ST_ACTIVE));
      $display("test reset done");
   endtask
   task automatic t_bist();
      do_reset();
      bist(1'b0);
      rc(OFS_ST, 32'h7, 32'(ST_LOCK));
      chk("rails_off", 32'(roff), 32'h1);
      rc(OFS_STS, '1, 32'h100);
      do_reset();
      wr(OFS_CTRL, 32'h37);
      bist(1'b0);
      bist(1'b1);
      rc(OFS_STS, '1, 32'h100);
      wr(OFS_STS, 32'h100);
      rc(OFS_ST, 32'h7, 32'(ST_ACTIVE));
      $display("test selftest done");
   endtask
   task automatic t_uv();
      boot(32'hc3);
      wr(OFS_DB, 32'h1);
      uv <= 4'h4;
      cyc(30);
      rc(OFS_STS, '1, 32'h0);
      cyc(15);
      rc(OFS_STS, '1, 32'h4);
      chk("int_n", 32'(intn), 32'h0);
      chk("rails_off", 32'(roff), 32'h1);
      chk("rst_n", 32'(rstn), 32'h0);
      boot(32'h1c0);
      wr(OFS_DB, 32'h7);
      uv <= 4'h2;
      cyc(4);
      rc(OFS_STS, '1, 32'h2);
      chk("int_n", 32'(intn), 32'h0);
      chk("rails_off", 32'(roff), 32'h0);
      chk("rst_n", 32'(rstn), 32'h1);
      $display("test window done");
   endtask
   task automatic t_ilim();
      for (int k = 0; k < 2; k++)
      begin
         boot(32'hf0);
         uv <= (k == 0) ? 4'h1 : 4'h0;
         ov <= (k == 1) ? 4'h1 : 4'h0;
         cyc(30);
         for (int p = 0; p < 2; p++)
         begin
            chk("rails_off", 32'(roff), 32'h0);
            ilp <= (k == 0) ? 4'h1 : 4'h0;
            iln <= (k == 1) ? 4'h1 : 4'h0;
            cyc(3);
            {ilp, iln} <= '0;
            cyc(3);
         end
         cyc(4);
         chk("rails_off", 32'(roff), 32'h1);
         rc(OFS_ST, 32'h7, 32'(ST_ERRPD));
      end
      $display("test current limit done");
   endtask
   task automatic t_short();
      boot(32'hc0);
      crs <= 1'b1;
      cyc(6);
      rc(OFS_ST, 32'h7, 32'(ST_RESET));
      chk("rst_n", 32'(rstn), 32'h0);
      crs <= 1'b0;
      cyc(6);
      rd(OFS_ST, q);
      chk("left reset", 32'(q[2:0] == 3'h4), 32'h0);
      boot(32'hc0);
      sws <= 4'h8;
      cyc(6);
      chk("rails_off", 32'(roff), 32'h1);
      boot(32'hc0);
      ckf <= 1'b1;
      cyc(6);
      ckf <= 1'b0;
      wr(OFS_CTRL, 32'h8000_00c0);
      cyc(4);
      rc(OFS_ST, 32'h30, 32'h30);
      chk("rst_n", 32'(rstn), 32'h0);
      $display("test shorts done");
   endtask
   task automatic t_ecc();
      boot(32'hf0);
      otp(32'h20);
      chk("payload", 32'(pay), 32'h0);
      rc(OFS_OTP, '1, 32'h0);
      rc(OFS_STS, '1, 32'h100);
      rc(OFS_ST, 32'h7, 32'(ST_FLAG));
      wr(OFS_STS, 32'h100);
      otp(32'h28);
      rc(OFS_ST, 32'h7, 32'(ST_LOCK));
      chk("rails_off", 32'(roff), 32'h1);
      // host must clear the flag before unlocking
      wr(OFS_CTRL, 32'h8000_00c0);
      rc(OFS_ST, 32'h7, 32'(ST_LOCK));
      wr(OFS_STS, 32'h100);
      wr(OFS_CTRL, 32'h8000_00c0);
      cyc(2);
      rc(OFS_ST, 32'h7, 32'(ST_BIST));
      $display("test memory done");
   endtask
   task automatic t_ka();
      boot(32'h13);
      rc(OFS_STS, '1, 32'h0);
      cyc(25);
      rc(OFS_STS, '1, 32'h200);
      chk("int_n", 32'(intn), 32'h0);
      rc(OFS_ST, 32'h7, 32'(ST_FLAG));
      cyc(20);
      rc(OFS_STS, 32'h400, 32'h400);
      $display("test keep-alive done");
   endtask

   initial
   begin
      t_reset();
      t_bist();
      t_uv();
      t_ilim();
      t_short();
      t_ecc();
      t_ka();
      fail_count += lapses;
      close_out();
   end
endmodule
